// ---- include/gpp_pkg.sv ----
// Package for the three-bit GPIO port with pull-ups and its wide sibling.
// Assumes a plain register port with one-cycle strobes and 8-bit data.
package gpp_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [3:0] OFF_WIDE_PIN = 4'h0;
    localparam logic [3:0] OFF_WIDE_LAT = 4'h1;
    localparam logic [3:0] OFF_WIDE_DIR = 4'h2;
    localparam logic [3:0] OFF_NARROW_PIN = 4'h3;
    localparam logic [3:0] OFF_NARROW_LAT = 4'h4;
    localparam logic [3:0] OFF_NARROW_DIR = 4'h5;
    localparam logic [3:0] OFF_ANALOG_CFG = 4'h6;
    localparam logic [3:0] OFF_ALT_CTRL = 4'h7;
    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int NARROW_PU_BIT = 6;
    localparam int WIDE_PU_BIT = 7;
    localparam int ANALOG_LSB = 5;
    localparam logic [7:0] WIDE_DIR_RST = 8'hFF;
    localparam logic [7:0] NARROW_DIR_RST = 8'h07;
    localparam logic [7:0] ANALOG_CFG_RST = 8'hE0;
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] ALT_CTRL_RST = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage

// ---- rtl/gpp_pin_cell.sv ----
// One general-purpose pin: driver, pull-up and input gate.
// Assumes pin input already synchronous to the system clock.
`timescale 1ns/10ps
module gpp_pin_cell (
    input wire logic i_dir_in,
    input wire logic i_latch,
    input wire logic i_alt_en,
    input wire logic i_alt_val,
    input wire logic i_pu_en,
    input wire logic i_analog,
    input wire logic i_pin,
    output logic o_pin_out,
    output logic o_pin_oe,
    output logic o_pullup,
    output logic o_dig_in
);
    // Driver off in input mode; alternate output replaces latch
    assign o_pin_oe = ~i_dir_in;
    assign o_pin_out = i_alt_en ? i_alt_val : i_latch;
    // Pull-up off whenever the pin drives
    assign o_pullup = i_pu_en & i_dir_in;
    // Digital input gated off while analog is selected
    assign o_dig_in = i_pin & ~i_analog;
endmodule // gpp_pin_cell

// ---- rtl/gpp_port.sv ----
// Top of the three-bit port, pull-up controls and wide sibling port.
// Assumes synchronous pin inputs and a master that never waits.
`timescale 1ns/10ps
module gpp_port #(
    parameter int NARROW_W = 3,
    parameter int WIDE_W = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [NARROW_W-1:0] i_narrow_pin,
    output logic [NARROW_W-1:0] o_narrow_out,
    output logic [NARROW_W-1:0] o_narrow_oe,
    output logic [NARROW_W-1:0] o_narrow_pullup,
    input wire logic i_parallel_read_strobe,
    input wire logic i_parallel_write_strobe,
    input wire logic i_parallel_byte_enable,
    input wire logic [WIDE_W-1:0] i_wide_pin,
    output logic [WIDE_W-1:0] o_wide_out,
    output logic [WIDE_W-1:0] o_wide_oe,
    output logic [WIDE_W-1:0] o_wide_pullup,
    input wire logic i_parallel_data_bit6,
    input wire logic i_parallel_data_bit7,
    input wire logic i_remap_pin_twenty_three,
    input wire logic i_remap_pin_twenty_four,
    output logic [gpp_pkg::ANALOG_LSB+2:0] o_analog_sel
);
    import gpp_pkg::*;

    generate
        if (NARROW_W != 3 || WIDE_W != 8) begin : g_bad_param
            $error("gpp_port supports only NARROW_W 3 and WIDE_W 8");
        end
    endgenerate

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] wide_lat_q;
    logic [7:0] wide_dir_q;
    logic [2:0] narrow_lat_q;
    logic [2:0] narrow_dir_q;
    logic narrow_pu_q;
    logic wide_pu_q;
    logic [7:0] analog_q;
    logic [7:0] alt_q;
    logic [7:0] rdata_q;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire logic wr_en = i_clk_en & i_wr;
    wire logic rd_en = i_clk_en & i_rd;
    wire logic wr_wide_lat = wr_en & (i_addr == OFF_WIDE_LAT);
    wire logic wr_wide_dir = wr_en & (i_addr == OFF_WIDE_DIR);
    wire logic wr_narrow_lat = wr_en & (i_addr == OFF_NARROW_LAT);
    wire logic wr_narrow_dir = wr_en & (i_addr == OFF_NARROW_DIR);
    wire logic wr_analog = wr_en & (i_addr == OFF_ANALOG_CFG);
    wire logic wr_alt = wr_en & (i_addr == OFF_ALT_CTRL);
    // Writing a pin value register writes its latch
    wire logic wr_wide_pin = wr_en & (i_addr == OFF_WIDE_PIN);
    wire logic wr_narrow_pin = wr_en & (i_addr == OFF_NARROW_PIN);

    // Alternate control: bits 0..2 enable strobes on narrow pins,
    // bits 6..7 enable parallel data on wide pins 6/7, bits 4..5 remap.
    wire logic [2:0] narrow_alt_en = alt_q[2:0];
    wire logic [2:0] narrow_alt_val = {i_parallel_byte_enable,
        i_parallel_write_strobe, i_parallel_read_strobe};
    wire logic [7:0] wide_alt_en = {alt_q[7] | alt_q[5],
        alt_q[6] | alt_q[4], 6'h00};
    wire logic [7:0] wide_alt_val = {
        alt_q[5] ? i_remap_pin_twenty_four : i_parallel_data_bit7,
        alt_q[4] ? i_remap_pin_twenty_three : i_parallel_data_bit6,
        6'h00};

    // ****************************************************************
    // Pin cells
    // ****************************************************************
    logic [2:0] narrow_dig;
    logic [7:0] wide_dig;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_narrow
            gpp_pin_cell u_cell (
                .i_dir_in(narrow_dir_q[g]),
                .i_latch(narrow_lat_q[g]),
                .i_alt_en(narrow_alt_en[g]),
                .i_alt_val(narrow_alt_val[g]),
                .i_pu_en(narrow_pu_q),
                .i_analog(analog_q[ANALOG_LSB+g]),
                .i_pin(i_narrow_pin[g]),
                .o_pin_out(o_narrow_out[g]),
                .o_pin_oe(o_narrow_oe[g]),
                .o_pullup(o_narrow_pullup[g]),
                .o_dig_in(narrow_dig[g])
            );
        end
        for (g = 0; g < 8; g++) begin : g_wide
            gpp_pin_cell u_cell (
                .i_dir_in(wide_dir_q[g]),
                .i_latch(wide_lat_q[g]),
                .i_alt_en(wide_alt_en[g]),
                .i_alt_val(wide_alt_val[g]),
                .i_pu_en(wide_pu_q),
                .i_analog(1'b0),
                .i_pin(i_wide_pin[g]),
                .o_pin_out(o_wide_out[g]),
                .o_pin_oe(o_wide_oe[g]),
                .o_pullup(o_wide_pullup[g]),
                .o_dig_in(wide_dig[g])
            );
        end
    endgenerate

    assign o_analog_sel = analog_q;

    // ****************************************************************
    // Read mux
    // ****************************************************************
    logic [7:0] rd_mux;
    always_comb begin
        case (i_addr)
            OFF_WIDE_PIN: rd_mux = wide_dig;
            OFF_WIDE_LAT: rd_mux = wide_lat_q;
            OFF_WIDE_DIR: rd_mux = wide_dir_q;
            OFF_NARROW_PIN: rd_mux = {5'h00, narrow_dig};
            OFF_NARROW_LAT: rd_mux = {5'h00, narrow_lat_q};
            OFF_NARROW_DIR: rd_mux = {wide_pu_q, narrow_pu_q, 3'h0,
                narrow_dir_q};
            OFF_ANALOG_CFG: rd_mux = analog_q;
            OFF_ALT_CTRL: rd_mux = alt_q;
            default: rd_mux = READ_UNMAPPED;
        endcase
    end

    // ****************************************************************
    // Register updates
    // ****************************************************************
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wide_lat_q <= LAT_RST;
            wide_dir_q <= WIDE_DIR_RST;
            narrow_lat_q <= LAT_RST[2:0];
            narrow_dir_q <= NARROW_DIR_RST[2:0];
            narrow_pu_q <= 1'b0;
            wide_pu_q <= 1'b0;
            analog_q <= ANALOG_CFG_RST;
            alt_q <= ALT_CTRL_RST;
            rdata_q <= 8'h00;
        end else if (i_clk_en) begin
            if (wr_wide_lat || wr_wide_pin) begin
                wide_lat_q <= i_wdata;
            end
            if (wr_wide_dir) begin
                wide_dir_q <= i_wdata;
            end
            if (wr_narrow_lat || wr_narrow_pin) begin
                narrow_lat_q <= i_wdata[2:0];
            end
            if (wr_narrow_dir) begin
                narrow_dir_q <= i_wdata[2:0];
                narrow_pu_q <= i_wdata[NARROW_PU_BIT];
                wide_pu_q <= i_wdata[WIDE_PU_BIT];
            end
            if (wr_analog) begin
                analog_q <= i_wdata;
            end
            if (wr_alt) begin
                alt_q <= i_wdata;
            end
            if (rd_en) begin
                rdata_q <= rd_mux;
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign o_rdata = rdata_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    dir_in_hiz_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        narrow_dir_q[0] |-> !o_narrow_oe[0])
        else $error("input pin driven");
    dir_out_drive_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!narrow_dir_q[1] && !alt_q[1]) |->
        (o_narrow_oe[1] && o_narrow_out[1] == narrow_lat_q[1]))
        else $error("output pin not following latch");
    analog_read_zero_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rd_en && i_addr == OFF_NARROW_PIN && analog_q[ANALOG_LSB+2])
        |=> !o_rdata[2])
        else $error("analog pin read nonzero");
    analog_drive_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (analog_q[ANALOG_LSB] && !narrow_dir_q[0] && !alt_q[0]) |->
        o_narrow_out[0] == narrow_lat_q[0])
        else $error("analog select altered output");
    latch_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rd_en && i_addr == OFF_NARROW_LAT) |=>
        o_rdata == {5'h00, $past(narrow_lat_q)})
        else $error("latch read wrong");
    pullup_out_off_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_narrow_oe[2] |-> !o_narrow_pullup[2])
        else $error("pull-up on driving pin");
    pullup_write_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (wr_narrow_dir && i_wdata[NARROW_PU_BIT] && i_wdata[0]) |=>
        o_narrow_pullup[0])
        else $error("pull-up enable ignored");
    wide_pullup_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (wr_narrow_dir && !i_wdata[WIDE_PU_BIT]) |=> o_wide_pullup == 8'h00)
        else $error("wide pull-ups not disabled");
    unimpl_zero_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rd_en && i_addr == OFF_NARROW_DIR) |=> o_rdata[5:3] == 3'h0)
        else $error("unimplemented bits nonzero");
    wide_pin_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rd_en && i_addr == OFF_WIDE_PIN) |=>
        o_rdata[7:6] == $past(i_wide_pin[7:6]))
        else $error("wide pin read wrong");

    // ****************************************************************
    // Reset, register and alternate checks
    // ****************************************************************
    reset_analog_a: assert property (
        @(posedge i_sys_clk)
        !i_rst_n |=> o_analog_sel == ANALOG_CFG_RST)
        else $error("analog select not forced by reset");
    reset_pullup_a: assert property (
        @(posedge i_sys_clk)
        !i_rst_n |=> (o_narrow_pullup == '0 && o_wide_pullup == '0))
        else $error("pull-ups enabled after reset");
    pullup_off_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (wr_narrow_dir && !i_wdata[NARROW_PU_BIT]) |=> o_narrow_pullup == '0)
        else $error("pull-up disable ignored");
    analog_dir_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (analog_q[ANALOG_LSB+1] && !narrow_dir_q[1]) |-> o_narrow_oe[1])
        else $error("analog select released the driver");
    pin_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rd_en && i_addr == OFF_NARROW_PIN &&
        analog_q[ANALOG_LSB +: 3] == 3'h0) |=>
        o_rdata == {5'h00, $past(i_narrow_pin)})
        else $error("narrow pin read wrong");
    strobe_alt_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        alt_q[2:0] == 3'h7 |-> o_narrow_out == {i_parallel_byte_enable,
        i_parallel_write_strobe, i_parallel_read_strobe})
        else $error("strobe not routed to narrow pin");
    remap_wins_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (alt_q[5] && alt_q[7]) |-> o_wide_out[7] == i_remap_pin_twenty_four)
        else $error("remap output lost to parallel data");
    wide_drive_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!wide_dir_q[6] && !alt_q[6] && !alt_q[4]) |->
        (o_wide_oe[6] && o_wide_out[6] == wide_lat_q[6]))
        else $error("wide pin not driving its latch");
    unmapped_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (rd_en && i_addr > OFF_ALT_CTRL) |=> o_rdata == READ_UNMAPPED)
        else $error("unmapped read nonzero");
    pin_write_latch_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        wr_narrow_pin |=> narrow_lat_q == $past(i_wdata[2:0]))
        else $error("pin value write missed the latch");
    enable_freeze_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_clk_en |=> ($stable(narrow_lat_q) && $stable(o_rdata)))
        else $error("state moved while clock enable low");

    // ****************************************************************
    // Per-pin checks
    // ****************************************************************
    generate
        for (g = 0; g < 3; g++) begin : g_pin_chk
            pin_hiz_a: assert property (
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                narrow_dir_q[g] |-> !o_narrow_oe[g])
                else $error("input pin driven");
            pin_latch_a: assert property (
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                (!narrow_dir_q[g] && !alt_q[g]) |->
                (o_narrow_oe[g] && o_narrow_out[g] == narrow_lat_q[g]))
                else $error("output pin not following latch");
            pin_pullup_a: assert property (
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                !narrow_dir_q[g] |-> !o_narrow_pullup[g])
                else $error("pull-up on driving pin");
            pin_gate_a: assert property (
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                analog_q[ANALOG_LSB+g] |-> !narrow_dig[g])
                else $error("analog pin passed digital input");
        end
        for (g = 0; g < 8; g++) begin : g_wide_chk
            wide_hiz_a: assert property (
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                wide_dir_q[g] |-> !o_wide_oe[g])
                else $error("wide input pin driven");
            wide_pu_out_a: assert property (
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                !wide_dir_q[g] |-> !o_wide_pullup[g])
                else $error("wide pull-up on driving pin");
            wide_pu_on_a: assert property (
                @(posedge i_sys_clk) disable iff (!i_rst_n)
                (wide_pu_q && wide_dir_q[g]) |-> o_wide_pullup[g])
                else $error("wide pull-up enable ignored");
        end
    endgenerate
endmodule // gpp_port

// ---- tb/gpp_pin_model.sv ----
// External circuitry on the package pins of one port.
// Assumes the design's enable is high while it drives a pin.
`timescale 1ns/10ps
module gpp_pin_model #(
    parameter int W = 3
) (
    input wire logic i_sys_clk,
    input wire logic [W-1:0] i_out,
    input wire logic [W-1:0] i_oe,
    input wire logic [W-1:0] i_pullup,
    input wire logic [W-1:0] i_ext_val,
    input wire logic [W-1:0] i_ext_en,
    output logic [W-1:0] o_pin
);
    logic [W-1:0] float_q = '0;
    // Undriven, unpulled lines change every cycle
    always @(posedge i_sys_clk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (i_oe[i]) o_pin[i] = i_out[i];
            else if (i_ext_en[i]) o_pin[i] = i_ext_val[i];
            else if (i_pullup[i]) o_pin[i] = 1'b1;
            else o_pin[i] = float_q[i];
        end
    end
endmodule // gpp_pin_model

// ---- tb/test_three_bit_port_with_pullups.sv ----
// Self-checking bench for the narrow port, its pull-ups and the wide port.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/10ps
module test_three_bit_port_with_pullups;
    import gpp_pkg::*;
    logic sys_clk = 0, rst_n = 0, clk_en = 1, wr = 0, rd = 0;
    logic [3:0] addr = '0, w_alt = '0;
    logic [7:0] wdata = '0, rdata, asel, w_pin, w_out, w_oe, w_pu;
    logic [7:0] w_ext = '0, w_ext_en = '0;
    logic [2:0] n_pin, n_out, n_oe, n_pu, strb = '0;
    logic [2:0] n_ext = '0, n_ext_en = '0;
    int bad_count = 0, checked = 0, cycles = 0;
    always #25 sys_clk = ~sys_clk;
    gpp_port #(.NARROW_W(3), .WIDE_W(8)) gpp_port_inst (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_narrow_pin(n_pin), .o_narrow_out(n_out),
        .o_narrow_oe(n_oe), .o_narrow_pullup(n_pu),
        .i_parallel_read_strobe(strb[0]),
        .i_parallel_write_strobe(strb[1]),
        .i_parallel_byte_enable(strb[2]), .i_wide_pin(w_pin),
        .o_wide_out(w_out), .o_wide_oe(w_oe), .o_wide_pullup(w_pu),
        .i_parallel_data_bit6(w_alt[0]), .i_parallel_data_bit7(w_alt[1]),
        .i_remap_pin_twenty_three(w_alt[2]),
        .i_remap_pin_twenty_four(w_alt[3]), .o_analog_sel(asel));
    gpp_pin_model #(.W(3)) gpp_pin_model_inst (.i_sys_clk(sys_clk),
        .i_out(n_out), .i_oe(n_oe), .i_pullup(n_pu), .i_ext_val(n_ext),
        .i_ext_en(n_ext_en), .o_pin(n_pin));
    gpp_pin_model #(.W(8)) gpp_pin_model_wide_inst (.i_sys_clk(sys_clk),
        .i_out(w_out), .i_oe(w_oe), .i_pullup(w_pu), .i_ext_val(w_ext),
        .i_ext_en(w_ext_en), .o_pin(w_pin));
    // ****************************************************************
    // Bus cycles, comparison and expectations
    // ****************************************************************
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        cmp(rdata, exp);
    endtask
    // Input pins show the far side, output pins their latch
    function automatic logic [7:0] exp_pin(input logic [7:0] d, l, e, an);
        return ((d & e) | (~d & l)) & ~an;
    endfunction
    task automatic end_sim();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        logic [7:0] d, l, e, nd, nl, ne, an, ac, ex;
        d = $urandom(95403);
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk_rd(OFF_WIDE_DIR, WIDE_DIR_RST);
        chk_rd(OFF_NARROW_DIR, NARROW_DIR_RST);
        chk_rd(OFF_ANALOG_CFG, ANALOG_CFG_RST);
        chk_rd(OFF_NARROW_LAT, LAT_RST);
        chk_rd(4'hB, READ_UNMAPPED);
        cmp({5'h0, n_pu | n_oe}, 8'h00);
        cmp(asel, 8'hE0);
        @(posedge sys_clk);
        n_ext <= 3'h7;
        n_ext_en <= 3'h7;
        chk_rd(OFF_NARROW_PIN, 8'h00);
        $display("test reset done");
        wr_reg(OFF_ANALOG_CFG, 8'h00);
        wr_reg(OFF_NARROW_DIR, 8'hFF);
        n_ext_en <= 3'h0;
        chk_rd(OFF_NARROW_DIR, 8'hC7);
        cmp({5'h0, n_pu}, 8'h07);
        chk_rd(OFF_NARROW_PIN, 8'h07);
        cmp(w_pu, 8'hFF);
        wr_reg(OFF_NARROW_DIR, 8'h45);
        wr_reg(OFF_WIDE_DIR, 8'h0F);
        cmp({2'h0, n_pu, n_oe}, 8'h2A);
        cmp(w_pu, 8'h00);
        $display("test pull-ups done");
        for (int k = 0; k < 20; k++) begin
            nd = $urandom;
            nl = $urandom & 8'h07;
            ne = $urandom & 8'h07;
            an = $urandom;
            d = $urandom;
            l = $urandom;
            e = $urandom;
            wr_reg(OFF_ANALOG_CFG, an);
            wr_reg(OFF_NARROW_DIR, nd);
            wr_reg(k[0] ? OFF_NARROW_PIN : OFF_NARROW_LAT, nl);
            wr_reg(OFF_WIDE_DIR, d);
            wr_reg(k[0] ? OFF_WIDE_PIN : OFF_WIDE_LAT, l);
            n_ext <= ne[2:0];
            n_ext_en <= nd[2:0];
            w_ext <= e;
            w_ext_en <= d;
            chk_rd(OFF_NARROW_LAT, nl);
            ex = exp_pin(nd & 8'h07, nl, ne, an >> 5);
            chk_rd(OFF_NARROW_PIN, ex);
            chk_rd(OFF_WIDE_PIN, exp_pin(d, l, e, 8'h00));
            chk_rd(OFF_WIDE_LAT, l);
            cmp({5'h0, n_oe}, {5'h0, ~nd[2:0]});
            cmp({5'h0, n_out}, nl);
            cmp({5'h0, n_pu}, {5'h0, nd[2:0] & {3{nd[6]}}});
            cmp(w_pu, d & {8{nd[7]}});
            cmp(w_oe, ~d);
        end
        $display("test random port traffic done");
        wr_reg(OFF_NARROW_LAT, 8'h00);
        wr_reg(OFF_WIDE_LAT, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            ac = k[0] ? 8'hF7 : 8'hC7;
            wr_reg(OFF_ALT_CTRL, ac);
            strb <= 3'($urandom);
            w_alt <= 4'($urandom);
            @(negedge sys_clk);
            cmp({5'h0, n_out}, {5'h0, strb});
            cmp(w_out, {k[0] ? w_alt[3:2] : w_alt[1:0], 6'h3F});
        end
        $display("test alternate outputs done");
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr_reg(OFF_NARROW_LAT, 8'hFF);
        clk_en <= 1'b1;
        chk_rd(OFF_NARROW_LAT, 8'h00);
        wr_reg(OFF_NARROW_LAT, 8'hFF);
        chk_rd(OFF_NARROW_LAT, 8'h07);
        $display("test clock enable done");
        end_sim();
    end
endmodule // test_three_bit_port_with_pullups
